// *** core/abu_bcd_conv.sv ***
// sequential packed-bcd to binary and binary to packed-bcd converter
`timescale 1ns/100ps
module abu_bcd_conv (
  input  wire logic                      ref_clk,
  input  wire logic                      rst_n,
  input  wire logic                      start,
  input  wire logic                      to_bcd,
  input  wire logic [abu_pkg::ACC_W-1:0] data_in,
  output logic                           busy,
  output logic                           done,
  output logic [abu_pkg::ACC_W-1:0]      data_out
);
  logic [abu_pkg::ACC_W-1:0]  bin_reg;
  logic [abu_pkg::BCD_W-1:0]  bcd_reg;
  logic [abu_pkg::STEP_W-1:0] step_reg;
  logic                       dir_reg;
  logic                       busy_reg;
  logic                       done_reg;
  logic [abu_pkg::ACC_W-1:0]  out_reg;
  logic [abu_pkg::BCD_W-1:0]  bcd_adj;
  logic [abu_pkg::DIGIT_W-1:0] top_digit;
  logic [abu_pkg::ACC_W-1:0]  bin_next;

  // add three to every digit of five or more before each doubling
  always_comb begin
    for (int d = 0; d < abu_pkg::BCD_W / abu_pkg::DIGIT_W; d++) begin
      if (bcd_reg[d*abu_pkg::DIGIT_W +: abu_pkg::DIGIT_W] >= abu_pkg::DIGIT_ADJ_MIN) begin
        bcd_adj[d*abu_pkg::DIGIT_W +: abu_pkg::DIGIT_W] =
          bcd_reg[d*abu_pkg::DIGIT_W +: abu_pkg::DIGIT_W] + abu_pkg::DIGIT_ADJ;
      end else begin
        bcd_adj[d*abu_pkg::DIGIT_W +: abu_pkg::DIGIT_W] =
          bcd_reg[d*abu_pkg::DIGIT_W +: abu_pkg::DIGIT_W];
      end
    end
  end

  // most significant digit first: value times ten plus digit
  assign top_digit = bcd_reg[abu_pkg::ACC_W-1 -: abu_pkg::DIGIT_W];
  assign bin_next  = (bin_reg << 3) + (bin_reg << 1)
                   + {{(abu_pkg::ACC_W-abu_pkg::DIGIT_W){1'b0}}, top_digit};

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bin_reg  <= abu_pkg::ACC_RESET;
      bcd_reg  <= '0;
      step_reg <= abu_pkg::STEP_ZERO;
      dir_reg  <= 1'b0;
      busy_reg <= 1'b0;
    end else if (start && !busy_reg) begin
      dir_reg  <= to_bcd;
      busy_reg <= 1'b1;
      if (to_bcd) begin
        bin_reg  <= data_in;
        bcd_reg  <= '0;
        step_reg <= abu_pkg::BIN_STEPS;
      end else begin
        bin_reg  <= abu_pkg::ACC_ZERO;
        bcd_reg  <= {{(abu_pkg::BCD_W-abu_pkg::ACC_W){1'b0}}, data_in};
        step_reg <= abu_pkg::BCD_STEPS;
      end
    end else if (busy_reg) begin
      step_reg <= step_reg - abu_pkg::STEP_ONE;
      if (step_reg == abu_pkg::STEP_ONE) begin
        busy_reg <= 1'b0;
      end
      if (dir_reg) begin
        bcd_reg <= {bcd_adj[abu_pkg::BCD_W-2:0], bin_reg[abu_pkg::ACC_W-1]};
        bin_reg <= {bin_reg[abu_pkg::ACC_W-2:0], 1'b0};
      end else begin
        bin_reg <= bin_next;
        bcd_reg <= {bcd_reg[abu_pkg::BCD_W-abu_pkg::DIGIT_W-1:0], {abu_pkg::DIGIT_W{1'b0}}};
      end
    end
  end

  // result register and one-cycle completion pulse
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      done_reg <= 1'b0;
      out_reg  <= abu_pkg::ACC_RESET;
    end else begin
      done_reg <= busy_reg && (step_reg == abu_pkg::STEP_ONE);
      if (busy_reg && (step_reg == abu_pkg::STEP_ONE)) begin
        if (dir_reg) begin
          out_reg <= bcd_adj[abu_pkg::ACC_W-2:0] == '0 && !bin_reg[abu_pkg::ACC_W-1]
                   ? abu_pkg::ACC_ZERO
                   : {bcd_adj[abu_pkg::ACC_W-2:0], bin_reg[abu_pkg::ACC_W-1]};
        end else begin
          out_reg <= bin_next;
        end
      end
    end
  end

  assign busy     = busy_reg;
  assign done     = done_reg;
  assign data_out = out_reg;
endmodule : abu_bcd_conv

// *** core/abu_pkg.sv ***
// constants and opcode encoding for the accumulator bit-operation unit
package abu_pkg;
  localparam int unsigned ACC_W      = 32;
  localparam int unsigned CNT_W      = 16;
  localparam int unsigned IDX_W      = 5;
  localparam int unsigned DIGIT_W    = 4;
  localparam int unsigned BCD_DIGITS = 8;
  localparam int unsigned BCD_W      = 40;
  localparam int unsigned STEP_W     = 6;
  localparam int unsigned DEC_GROUPS = 7;

  localparam logic [CNT_W-1:0]  IMM_MIN     = 16'h0001;
  localparam logic [CNT_W-1:0]  IMM_MAX     = 16'h0020;
  localparam logic [CNT_W-1:0]  FULL_COUNT  = 16'h0020;
  localparam logic [ACC_W-1:0]  ACC_RESET   = 32'h0000_0000;
  localparam logic [ACC_W-1:0]  ACC_ZERO    = 32'h0000_0000;
  localparam logic [ACC_W-1:0]  ACC_ONE     = 32'h0000_0001;
  localparam logic [ACC_W-1:0]  DEC_LIMIT   = 32'h0000_0020;
  localparam logic [DIGIT_W-1:0] DIGIT_ADJ_MIN = 4'h5;
  localparam logic [DIGIT_W-1:0] DIGIT_ADJ     = 4'h3;
  localparam logic [STEP_W-1:0] BIN_STEPS   = 6'h20;
  localparam logic [STEP_W-1:0] BCD_STEPS   = 6'h08;
  localparam logic [STEP_W-1:0] STEP_ONE    = 6'h01;
  localparam logic [STEP_W-1:0] STEP_ZERO   = 6'h00;

  typedef enum logic [3:0] {
    ABU_OP_LOAD      = 4'h0,
    ABU_OP_SHR       = 4'h1,
    ABU_OP_ROT_LEFT  = 4'h2,
    ABU_OP_ROT_RIGHT = 4'h3,
    ABU_OP_ENCODE    = 4'h4,
    ABU_OP_DECODE    = 4'h5,
    ABU_OP_BCD2BIN   = 4'h6,
    ABU_OP_BIN2BCD   = 4'h7,
    ABU_OP_INVERT    = 4'h8
  } abu_op_t;

  typedef enum logic {
    ABU_ST_IDLE = 1'b0,
    ABU_ST_CONV = 1'b1
  } abu_state_t;
endpackage : abu_pkg

// *** core/abu_unit.sv ***
// accumulator datapath for single-operand shift, rotate, encode, decode and conversions
`timescale 1ns/100ps
// How it works
// - a shift right moves all 32 accumulator bits toward bit 0 by the count and keeps the result.
// - a shift fills vacated positions with zero and drops the bits that leave.
// - the count comes from a memory word or an immediate, and an immediate must be 1 to 32.
// - a rotate left moves the 32 bits up by the count, with bit 31 wrapping into bit 0.
// - a rotate right moves the 32 bits down by the count, with bit 0 wrapping into bit 31.
// - encode replaces the accumulator with the index of its set bit, top bit giving 1F hex.
// - encode of zero or of only bit 0 set writes zero.
// - encode with several bits set gives the lowest set index and raises the overflow flag.
// - the overflow flag holds only until the next operation that uses the same flag.
// - decode of a value 0 to 31 sets only the bit at that index.
// - decode of a value above 31 divides by 32 until below 32, then decodes that.
// - bcd to binary reads the accumulator as packed bcd digits and writes the binary value.
// - binary to bcd writes the low 8 decimal digits of the accumulator value as packed bcd digits.
// - complement inverts all 32 accumulator bits.
module abu_unit (
  input  wire logic                      ref_clk,
  input  wire logic                      rst_n,
  input  wire logic                      op_valid,
  input  wire logic [3:0]                op_code,
  input  wire logic [abu_pkg::CNT_W-1:0] op_count,
  input  wire logic                      count_is_imm,
  input  wire logic [abu_pkg::ACC_W-1:0] load_data,
  output logic                           op_ready,
  output logic                           op_done,
  output logic                           count_range_error,
  output logic                           encode_overflow_flag,
  output logic [abu_pkg::ACC_W-1:0]      acc_out
);
  abu_pkg::abu_state_t        state_reg;
  abu_pkg::abu_op_t           op;
  logic [abu_pkg::ACC_W-1:0]  acc_reg;
  logic [abu_pkg::ACC_W-1:0]  acc_next;
  logic                       flag_reg;
  logic                       done_reg;
  logic                       err_reg;
  logic                       accept;
  logic                       imm_bad;
  logic                       is_conv;
  logic                       conv_busy;
  logic                       conv_done;
  logic [abu_pkg::ACC_W-1:0]  conv_data;

  function automatic logic [abu_pkg::ACC_W-1:0] shift_right(
    input logic [abu_pkg::ACC_W-1:0] v,
    input logic [abu_pkg::CNT_W-1:0] c
  );
    if (c >= abu_pkg::FULL_COUNT) begin
      shift_right = abu_pkg::ACC_ZERO;
    end else begin
      shift_right = v >> c[abu_pkg::IDX_W-1:0];
    end
  endfunction : shift_right

  function automatic logic [abu_pkg::ACC_W-1:0] rotate(
    input logic [abu_pkg::ACC_W-1:0] v,
    input logic [abu_pkg::CNT_W-1:0] c,
    input logic                      left
  );
    logic [2*abu_pkg::ACC_W-1:0] dbl;
    logic [abu_pkg::IDX_W-1:0]   n;
    dbl = {v, v};
    n   = c[abu_pkg::IDX_W-1:0];
    if (left) begin
      rotate = dbl[2*abu_pkg::ACC_W-1 - n -: abu_pkg::ACC_W];
    end else begin
      rotate = dbl[n +: abu_pkg::ACC_W];
    end
  endfunction : rotate

  function automatic logic [abu_pkg::ACC_W-1:0] lowest_index(
    input logic [abu_pkg::ACC_W-1:0] v
  );
    lowest_index = abu_pkg::ACC_ZERO;
    for (int i = abu_pkg::ACC_W - 1; i >= 0; i--) begin
      if (v[i]) begin
        lowest_index = i[abu_pkg::ACC_W-1:0];
      end
    end
  endfunction : lowest_index

  function automatic logic many_bits(
    input logic [abu_pkg::ACC_W-1:0] v
  );
    many_bits = (v & (v - abu_pkg::ACC_ONE)) != abu_pkg::ACC_ZERO;
  endfunction : many_bits

  function automatic logic [abu_pkg::ACC_W-1:0] decode_bit(
    input logic [abu_pkg::ACC_W-1:0] v
  );
    logic [abu_pkg::ACC_W-1:0] r;
    logic                      found;
    r     = v;
    found = 1'b0;
    for (int k = 0; k < abu_pkg::DEC_GROUPS; k++) begin
      if (!found && ((v >> (abu_pkg::IDX_W * k)) < abu_pkg::DEC_LIMIT)) begin
        r     = v >> (abu_pkg::IDX_W * k);
        found = 1'b1;
      end
    end
    decode_bit = abu_pkg::ACC_ONE << r[abu_pkg::IDX_W-1:0];
  endfunction : decode_bit

  assign op       = abu_pkg::abu_op_t'(op_code);
  assign imm_bad  = count_is_imm && ((op_count < abu_pkg::IMM_MIN) ||
                    (op_count > abu_pkg::IMM_MAX)) &&
                    (op == abu_pkg::ABU_OP_SHR || op == abu_pkg::ABU_OP_ROT_LEFT ||
                     op == abu_pkg::ABU_OP_ROT_RIGHT);
  assign is_conv  = (op == abu_pkg::ABU_OP_BCD2BIN) || (op == abu_pkg::ABU_OP_BIN2BCD);
  assign op_ready = (state_reg == abu_pkg::ABU_ST_IDLE) && !conv_busy;
  assign accept   = op_valid && op_ready;

  always_comb begin
    acc_next = acc_reg;
    unique case (op)
      abu_pkg::ABU_OP_LOAD:   acc_next = load_data;
      abu_pkg::ABU_OP_SHR:    acc_next = shift_right(acc_reg, op_count);
      abu_pkg::ABU_OP_ROT_LEFT:  acc_next = rotate(acc_reg, op_count, 1'b1);
      abu_pkg::ABU_OP_ROT_RIGHT: acc_next = rotate(acc_reg, op_count, 1'b0);
      abu_pkg::ABU_OP_ENCODE: acc_next = lowest_index(acc_reg);
      abu_pkg::ABU_OP_DECODE: acc_next = decode_bit(acc_reg);
      abu_pkg::ABU_OP_INVERT: acc_next = ~acc_reg;
      default:                acc_next = acc_reg;
    endcase
  end

  abu_bcd_conv u_conv (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .start    (accept && is_conv),
    .to_bcd   (op == abu_pkg::ABU_OP_BIN2BCD),
    .data_in  (acc_reg),
    .busy     (conv_busy),
    .done     (conv_done),
    .data_out (conv_data)
  );

  // issue sequencing: conversions hold off the next operation
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= abu_pkg::ABU_ST_IDLE;
    end else begin
      unique case (state_reg)
        abu_pkg::ABU_ST_IDLE: begin
          if (accept && is_conv) begin
            state_reg <= abu_pkg::ABU_ST_CONV;
          end
        end
        abu_pkg::ABU_ST_CONV: begin
          if (conv_done) begin
            state_reg <= abu_pkg::ABU_ST_IDLE;
          end
        end
      endcase
    end
  end

  // accumulator
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_reg <= abu_pkg::ACC_RESET;
    end else if (state_reg == abu_pkg::ABU_ST_CONV && conv_done) begin
      acc_reg <= conv_data;
    end else if (accept && !is_conv && !imm_bad) begin
      acc_reg <= acc_next;
    end
  end

  // encode overflow flag, rewritten only by the next encode
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_reg <= 1'b0;
    end else if (accept && op == abu_pkg::ABU_OP_ENCODE) begin
      flag_reg <= many_bits(acc_reg);
    end
  end

  // completion and count error pulses
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      done_reg <= 1'b0;
      err_reg  <= 1'b0;
    end else begin
      done_reg <= (accept && !is_conv) ||
                  (state_reg == abu_pkg::ABU_ST_CONV && conv_done);
      err_reg  <= accept && imm_bad;
    end
  end

  assign op_done              = done_reg;
  assign count_range_error    = err_reg;
  assign encode_overflow_flag = flag_reg;
  assign acc_out              = acc_reg;
endmodule : abu_unit

// *** sim/abu_seq_model.sv ***
// instruction sequencer model issuing accumulator operations
`timescale 1ns/100ps
module abu_seq_model (
  input  wire logic        ref_clk,
  input  wire logic        op_ready,
  input  wire logic        op_done,
  input  wire logic        count_range_error,
  output logic             op_valid,
  output logic [3:0]       op_code,
  output logic [15:0]      op_count,
  output logic             count_is_imm,
  output logic [31:0]      load_data
);
  initial begin
    op_valid = 1'b0;
    op_code = 4'h0;
    op_count = 16'h0000;
    count_is_imm = 1'b0;
    load_data = 32'h0000_0000;
  end
  // count goes out as immediate or memory word as asked
  task automatic run(input logic [3:0] c, input logic [15:0] n, input logic i,
                     input logic [31:0] d, output logic err, output logic late);
    int k;
    @(posedge ref_clk);
    op_valid <= 1'b1;
    op_code <= c;
    op_count <= n;
    count_is_imm <= i;
    load_data <= d;
    k = 0;
    do @(posedge ref_clk); while (op_ready !== 1'b1 && ++k < 50);
    late = (op_ready !== 1'b1);
    op_valid <= 1'b0;
    op_count <= ~n;
    load_data <= ~d;
    err = 1'b0;
    k = 0;
    do begin
      @(posedge ref_clk);
      err |= (count_range_error === 1'b1);
    end while (op_done !== 1'b1 && ++k < 50);
    late |= (op_done !== 1'b1);
  endtask : run
endmodule : abu_seq_model

// *** sim/abu_unit_chk.sv ***
// port checks for the accumulator bit-operation unit
`timescale 1ns/100ps
module abu_unit_chk (
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        op_valid,
  input wire logic [3:0]  op_code,
  input wire logic [15:0] op_count,
  input wire logic        count_is_imm,
  input wire logic [31:0] load_data,
  input wire logic        op_ready,
  input wire logic        op_done,
  input wire logic        count_range_error,
  input wire logic        encode_overflow_flag,
  input wire logic [31:0] acc_out
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic tk;
  assign tk = op_valid && op_ready;
  shr_fill_a: assert property (
    tk && op_code == 4'h1 && op_count inside {[16'h0001:16'h001F]}
    |=> acc_out == $past(acc_out) >> $past(op_count[4:0])) else $error("bad shift");
  rot_left_a: assert property (
    tk && op_code == 4'h2 && op_count inside {[16'h0001:16'h001F]}
    |=> acc_out == (($past(acc_out) << $past(op_count[4:0]))
    | ($past(acc_out) >> (6'h20 - $past(op_count[5:0]))))) else $error("bad rotate");
  rot_right_a: assert property (
    tk && op_code == 4'h3 && op_count inside {[16'h0001:16'h001F]}
    |=> acc_out == (($past(acc_out) >> $past(op_count[4:0]))
    | ($past(acc_out) << (6'h20 - $past(op_count[5:0]))))) else $error("bad rotate right");
  flag_hold_a: assert property (
    tk && op_code != 4'h4 |=> $stable(encode_overflow_flag)) else $error("flag changed");
  imm_range_a: assert property (
    tk && count_is_imm && op_code inside {4'h1, 4'h2, 4'h3}
    && (op_count == 16'h0000 || op_count > 16'h0020)
    |=> count_range_error && $stable(acc_out)) else $error("bad range");
  encode_flag_a: assert property (
    tk && op_code == 4'h4 |=> acc_out < 32'h20
    && encode_overflow_flag == ($countones($past(acc_out)) > 1)) else $error("bad encode");
  decode_bit_a: assert property (
    tk && op_code == 4'h5 && acc_out < 32'h20
    |=> acc_out == 32'h1 << $past(acc_out[4:0])) else $error("bad decode");
  invert_all_a: assert property (
    tk && op_code == 4'h8 |=> acc_out == ~$past(acc_out)) else $error("bad invert");
  single_done_a: assert property (
    tk && op_code < 4'h6 |=> op_done) else $error("late done");
  to_bcd_time_a: assert property (
    tk && op_code == 4'h7 |=> (!op_ready && !op_done)[*8] ##26 op_done)
    else $error("bad bcd timing");
  to_bin_time_a: assert property (
    tk && op_code == 4'h6 |=> !op_done[*8] ##2 op_done) else $error("bad bin timing");
endmodule : abu_unit_chk

// *** sim/abu_unit_tb.sv ***
// self-checking testbench for the accumulator bit-operation unit
`timescale 1ns/100ps
module abu_unit_tb;
  logic        ref_clk, rst_n, op_valid, count_is_imm, op_ready, op_done;
  logic        count_range_error, encode_overflow_flag, err, late;
  logic [3:0]  op_code;
  logic [15:0] op_count;
  logic [31:0] load_data, acc_out;
  int          fail_count, comparisons;
  abu_unit u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .op_valid(op_valid),
    .op_code(op_code), .op_count(op_count), .count_is_imm(count_is_imm),
    .load_data(load_data), .op_ready(op_ready), .op_done(op_done),
    .count_range_error(count_range_error),
    .encode_overflow_flag(encode_overflow_flag), .acc_out(acc_out));
  abu_seq_model u_seq (.ref_clk(ref_clk), .op_ready(op_ready), .op_done(op_done),
    .count_range_error(count_range_error), .op_valid(op_valid), .op_code(op_code),
    .op_count(op_count), .count_is_imm(count_is_imm), .load_data(load_data));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic op(input logic [3:0] c, input logic [15:0] n, input logic i,
                    input logic [31:0] d);
    u_seq.run(c, n, i, d, err, late);
    check({31'h0, late}, 32'h0);
  endtask : op
  task automatic t_shift;
    op(4'h0, 16'h0000, 1'b0, 32'hF000_000F);
    op(4'h1, 16'h000A, 1'b1, 32'h0);
    check(acc_out, 32'h003C_0000);
    op(4'h0, 16'h0000, 1'b0, 32'hFFFF_FFFF);
    op(4'h1, 16'h0020, 1'b1, 32'h0);
    check(acc_out, 32'h0000_0000);
    op(4'h0, 16'h0000, 1'b0, 32'hFFFF_FFFF);
    op(4'h1, 16'h0040, 1'b0, 32'h0);
    check(acc_out, 32'h0000_0000);
  endtask : t_shift
  task automatic t_rot;
    op(4'h0, 16'h0000, 1'b0, 32'h8000_0001);
    op(4'h2, 16'h0002, 1'b1, 32'h0);
    check(acc_out, 32'h0000_0006);
    op(4'h3, 16'h0003, 1'b0, 32'h0);
    check(acc_out, 32'hC000_0000);
    op(4'h2, 16'h0020, 1'b1, 32'h0);
    check(acc_out, 32'hC000_0000);
  endtask : t_rot
  task automatic t_range;
    op(4'h0, 16'h0000, 1'b0, 32'h1234_5678);
    op(4'h1, 16'h0000, 1'b1, 32'h0);
    check({31'h0, err}, 32'h1);
    op(4'h2, 16'h0021, 1'b1, 32'h0);
    check({31'h0, err}, 32'h1);
    check(acc_out, 32'h1234_5678);
  endtask : t_range
  task automatic t_enc;
    logic [31:0] v[4] = '{32'h0000_0A00, 32'h8000_0000, 32'h0, 32'h1};
    logic [31:0] e[4] = '{32'h9, 32'h1F, 32'h0, 32'h0};
    op(4'h0, 16'h0000, 1'b0, 32'h0000_0A00);
    op(4'h4, 16'h0000, 1'b0, 32'h0);
    op(4'h8, 16'h0000, 1'b0, 32'h0);
    check({31'h0, encode_overflow_flag}, 32'h1);
    for (int k = 0; k < 4; k++) begin
      op(4'h0, 16'h0000, 1'b0, v[k]);
      op(4'h4, 16'h0000, 1'b0, 32'h0);
      check(acc_out, e[k]);
      check({31'h0, encode_overflow_flag}, {31'h0, k == 0});
    end
  endtask : t_enc
  task automatic t_dec;
    logic [31:0] v[3] = '{32'hF, 32'h3F, 32'h3E8};
    logic [31:0] e[3] = '{32'h0000_8000, 32'h2, 32'h8000_0000};
    for (int k = 0; k < 3; k++) begin
      op(4'h0, 16'h0000, 1'b0, v[k]);
      op(4'h5, 16'h0000, 1'b0, 32'h0);
      check(acc_out, e[k]);
    end
  endtask : t_dec
  task automatic t_conv;
    op(4'h0, 16'h0000, 1'b0, 32'h1234_5678);
    op(4'h6, 16'h0000, 1'b0, 32'h0);
    check(acc_out, 32'h00BC_614E);
    op(4'h0, 16'h0000, 1'b0, 32'h05F5_E0FF);
    op(4'h7, 16'h0000, 1'b0, 32'h0);
    check(acc_out, 32'h9999_9999);
    op(4'h8, 16'h0000, 1'b0, 32'h0);
    check(acc_out, 32'h6666_6666);
    op(4'hF, 16'h0000, 1'b0, 32'h0);
    check(acc_out, 32'h6666_6666);
  endtask : t_conv
  task automatic summarize;
    $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : summarize
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  initial begin
    #20000;
    fail_count++;
    summarize();
  end
  initial begin
    rst_n = 1'b0;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_shift();
    t_rot();
    t_range();
    t_enc();
    t_dec();
    t_conv();
    summarize();
  end
endmodule : abu_unit_tb
bind abu_unit abu_unit_chk u_chk (.ref_clk(ref_clk), .rst_n(rst_n),
  .op_valid(op_valid), .op_code(op_code), .op_count(op_count),
  .count_is_imm(count_is_imm), .load_data(load_data), .op_ready(op_ready),
  .op_done(op_done), .count_range_error(count_range_error),
  .encode_overflow_flag(encode_overflow_flag), .acc_out(acc_out));
